// ===== verilog/short_fault_consts.vh
// Constants for the bridge short fault monitor
`ifndef SHORT_FAULT_CONSTS_VH
`define SHORT_FAULT_CONSTS_VH
`define LOG_WIDTH        10
`define LOG_CNT_W        4
`define LOG_LAST_IDX     4'd9
`define LOG_DONE_IDX     4'd10
`define BIT_HIGH_A       0
`define BIT_LOW_A        3
`define BIT_REG_UV       6
`define BIT_BOOT_A       7
`define BLANK_TIME_NS    2000
`define CLK_PERIOD_NS    8
`define BLANK_CYCLES     ((`BLANK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BLANK_CNT_W      9
`define FIFO_WIDTH       1
`define FIFO_DEPTH       32
`define FIFO_AW          5
`endif

// ===== verilog/bridge_short_fault_monitor.v
// Bridge short fault monitor with serial fault log readout
`timescale 1ns/1ps
`default_nettype none
`include "short_fault_consts.vh"

module bridge_short_fault_monitor (
  input  wire       clk,
  input  wire       rst_n,
  input  wire [5:0] fet_on_cmd,
  input  wire [5:0] ds_cmp_excess,
  input  wire       stop_on_fault_select,
  input  wire       reg_uv,
  input  wire       logic_uv,
  input  wire [2:0] boot_uv,
  input  wire       over_temp,
  input  wire       fault_flag_one_in,
  input  wire       fault_flag_two_in,
  output reg        fault_flag_one_out,
  output reg        fault_flag_one_oe,
  output reg        fault_flag_two_out,
  output reg        fault_flag_two_oe,
  output reg        gate_disable,
  output reg  [9:0] fault_log
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg  [5:0] on_s1_q, on_s2_q, cmp_s1_q, cmp_s2_q;
  reg  [6:0] st_s1_q, st_s2_q;
  reg        ff2_s1_q, ff2_s2_q, ff2_s3_q;
  wire       sof_s, reg_uv_s, logic_uv_s, ot_s;
  wire [2:0] boot_s;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      on_s1_q  <= 6'h00;
      on_s2_q  <= 6'h00;
      cmp_s1_q <= 6'h00;
      cmp_s2_q <= 6'h00;
      st_s1_q  <= 7'h00;
      st_s2_q  <= 7'h00;
      ff2_s1_q <= 1'b0;
      ff2_s2_q <= 1'b0;
      ff2_s3_q <= 1'b0;
    end else begin
      on_s1_q  <= fet_on_cmd;
      on_s2_q  <= on_s1_q;
      cmp_s1_q <= ds_cmp_excess;
      cmp_s2_q <= cmp_s1_q;
      st_s1_q  <= {stop_on_fault_select, reg_uv, logic_uv, boot_uv, over_temp};
      st_s2_q  <= st_s1_q;
      ff2_s1_q <= fault_flag_two_in;
      ff2_s2_q <= ff2_s1_q;
      ff2_s3_q <= ff2_s2_q;
    end
  end

  assign sof_s      = st_s2_q[6];
  assign reg_uv_s   = st_s2_q[5];
  assign logic_uv_s = st_s2_q[4];
  assign boot_s     = st_s2_q[3:1];
  assign ot_s       = st_s2_q[0];

  // ----------------------------------------------------------------
  // Blanking per FET
  // ----------------------------------------------------------------
  wire [5:0] blank_done;
  wire [5:0] short_det;

  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_blank
      fet_blank_timer u_blank (
        .clk    (clk),
        .rst_n  (rst_n),
        .fet_on (on_s2_q[g]),
        .done   (blank_done[g])
      );
    end
  endgenerate

  // Bits 0..2 high side (short to ground), 3..5 low side (short to supply)
  assign short_det = cmp_s2_q & on_s2_q & blank_done;

  // ----------------------------------------------------------------
  // Readout sequencer and fault log
  // ----------------------------------------------------------------
  reg  [9:0] log_q;
  reg  [3:0] idx_q;
  reg        rd_q;
  reg        short_lat_q;
  reg        boot_lat_q;
  reg        clear_q;
  wire       ff2_fall, ff2_rise, fault_rel, ff2_released;
  wire       short_flag, uv_flag;

  assign ff2_fall  = ff2_s3_q & ~ff2_s2_q;
  assign ff2_rise  = ~ff2_s3_q & ff2_s2_q;
  assign short_flag = short_lat_q | (|short_det);
  assign uv_flag    = reg_uv_s | logic_uv_s | boot_lat_q;
  assign ff2_released = (short_flag | uv_flag) & ~clear_q;
  assign fault_rel  = ff2_released;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      log_q       <= 10'h000;
      idx_q       <= 4'h0;
      rd_q        <= 1'b0;
      short_lat_q <= 1'b0;
      boot_lat_q  <= 1'b0;
      clear_q     <= 1'b0;
    end else if (logic_uv_s) begin
      log_q       <= 10'h000;
      idx_q       <= 4'h0;
      rd_q        <= 1'b0;
      short_lat_q <= 1'b0;
      boot_lat_q  <= 1'b0;
      clear_q     <= 1'b0;
    end else begin
      clear_q <= 1'b0;
      if (rd_q && ff2_fall && idx_q == `LOG_LAST_IDX) begin
        // New events in the clearing cycle win over the clear
        log_q       <= {boot_s, reg_uv_s, short_det};
        short_lat_q <= sof_s & (|short_det);
        boot_lat_q  <= |boot_s;
        idx_q       <= 4'h0;
        rd_q        <= 1'b0;
        clear_q     <= 1'b1;
      end else begin
        log_q <= log_q | {boot_s, reg_uv_s, short_det};
        if (sof_s && (|short_det))
          short_lat_q <= 1'b1;
        if (|boot_s)
          boot_lat_q <= 1'b1;
        if (!rd_q && fault_rel && ff2_fall) begin
          rd_q  <= 1'b1;
          idx_q <= 4'h0;
        end else if (rd_q && ff2_fall) begin
          idx_q <= idx_q + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Flag pin drive and outputs
  // ----------------------------------------------------------------
  reg  flag1_d, flag2_d;
  wire cur_bit;

  assign cur_bit = log_q[idx_q];

  always @* begin
    flag1_d = uv_flag | ot_s;
    flag2_d = ff2_released;
    if (rd_q)
      flag1_d = cur_bit;
    if (clear_q) begin
      flag1_d = 1'b0;
      flag2_d = 1'b0;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_flag_one_out <= 1'b0;
      fault_flag_one_oe  <= 1'b1;
      fault_flag_two_out <= 1'b0;
      fault_flag_two_oe  <= 1'b1;
      gate_disable       <= 1'b0;
      fault_log          <= 10'h000;
    end else begin
      fault_flag_one_out <= 1'b0;
      fault_flag_one_oe  <= ~flag1_d;
      fault_flag_two_out <= 1'b0;
      fault_flag_two_oe  <= ~(flag2_d | rd_q);
      gate_disable       <= short_lat_q | uv_flag | (sof_s & ot_s);
      fault_log          <= log_q;
    end
  end

  // Readback of pin level kept for completeness of the open-drain pin
  wire unused_ff1 = fault_flag_one_in | ff2_rise;

endmodule // bridge_short_fault_monitor

module fet_blank_timer (
  input  wire clk,
  input  wire rst_n,
  input  wire fet_on,
  output wire done
);
  reg [`BLANK_CNT_W-1:0] cnt_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      cnt_q <= {`BLANK_CNT_W{1'b0}};
    else if (!fet_on)
      cnt_q <= {`BLANK_CNT_W{1'b0}};
    else if (cnt_q != `BLANK_CYCLES)
      cnt_q <= cnt_q + 1'b1;
  end

  assign done = (cnt_q == `BLANK_CYCLES);
endmodule // fet_blank_timer

`default_nettype wire

// ===== tb/bsfm_chk.sv
// Checker for the bridge short fault monitor
`timescale 1ns/1ps
`default_nettype none
module bsfm_chk (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [5:0] fet_on_cmd,
  input wire logic       stop_on_fault_select,
  input wire logic       reg_uv,
  input wire logic       logic_uv,
  input wire logic [2:0] boot_uv,
  input wire logic       over_temp,
  input wire logic       fault_flag_one_out,
  input wire logic       fault_flag_one_oe,
  input wire logic       fault_flag_two_out,
  input wire logic       fault_flag_two_oe,
  input wire logic       gate_disable,
  input wire logic [9:0] fault_log
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  drain_only_a: assert property (!fault_flag_one_out && !fault_flag_two_out) else $error("flag data high");
  blank_hold_a: assert property ($rose(fault_log[0]) |-> $past(fet_on_cmd[0], 250)) else $error("blank");
  stop_gate_a: assert property ($rose(|fault_log[5:0]) && stop_on_fault_select |-> ##[0:4] gate_disable)
    else $error("no gate stop");
  short_flag_a: assert property ($rose(|fault_log[5:0]) |-> ##[0:4] !fault_flag_two_oe) else $error("flag two");
  uv_wipe_a: assert property (logic_uv [*5] |-> fault_log == 10'h000) else $error("log kept");
  uv_flags_a: assert property (reg_uv [*4] |-> !fault_flag_one_oe && !fault_flag_two_oe) else $error("uv flags");
  log_keep_a: assert property (fault_log != 10'h000 |=> fault_log == 10'h000 ||
    (fault_log & $past(fault_log)) == $past(fault_log)) else $error("log bit lost");
  esf_off_a: assert property ((!stop_on_fault_select && !reg_uv && !logic_uv && boot_uv == 3'h0 &&
    fault_log[9:7] == 3'h0) [*6] |-> !gate_disable) else $error("gates off");
  cover property ($fell(|fault_log) && !logic_uv);
  cover property (!stop_on_fault_select && !fault_flag_two_oe);
  cover property (over_temp && !fault_flag_one_oe);
endmodule // bsfm_chk
bind bridge_short_fault_monitor bsfm_chk u_bsfm_chk (.clk, .rst_n, .fet_on_cmd, .stop_on_fault_select,
  .reg_uv, .logic_uv, .boot_uv, .over_temp, .fault_flag_one_out, .fault_flag_one_oe, .fault_flag_two_out,
  .fault_flag_two_oe, .gate_disable, .fault_log);
`default_nettype wire

// ===== tb/flag_ctrl_model.sv
// Controller model that reads the fault log over the flag pins
`timescale 1ns/1ps
`default_nettype none
module flag_ctrl_model (
  input  wire logic flag_one_pin,
  output var  logic flag_two_pull
);
  initial flag_two_pull = 1'b0;
  task automatic read_log(output logic [9:0] bits);
    flag_two_pull = 1'b1;
    for (int i = 0; i < 10; i++) begin
      #160;
      bits[i] = flag_one_pin;
      flag_two_pull = 1'b0;
      #80;
      flag_two_pull = 1'b1;
    end
    #160;
    flag_two_pull = 1'b0;
  endtask
endmodule // flag_ctrl_model
`default_nettype wire

// ===== tb/tb_top.sv
// Testbench for the bridge short fault monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clk, rst_n, stop_on_fault_select, reg_uv, logic_uv, over_temp;
  logic       gate_disable, fault_flag_one_oe, fault_flag_two_oe, pull;
  logic [5:0] fet_on_cmd, ds_cmp_excess;
  logic [2:0] boot_uv;
  logic [9:0] fault_log, rd;
  wire logic  f1 = !fault_flag_one_oe;
  wire logic  f2 = !(fault_flag_two_oe || pull);
  int         mismatches = 0;
  int         checks = 0;
  bridge_short_fault_monitor u_bridge_short_fault_monitor (.clk, .rst_n, .fet_on_cmd, .ds_cmp_excess,
    .stop_on_fault_select, .reg_uv, .logic_uv, .boot_uv, .over_temp, .fault_flag_one_in(f1),
    .fault_flag_two_in(f2), .fault_flag_one_out(), .fault_flag_one_oe, .fault_flag_two_out(),
    .fault_flag_two_oe, .gate_disable, .fault_log);
  flag_ctrl_model u_flag_ctrl_model (.flag_one_pin(f1), .flag_two_pull(pull));
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_short();
    stop_on_fault_select = 1'b1;
    fet_on_cmd = 6'h09;
    ds_cmp_excess = 6'h09;
    step(200);
    chk(fault_log, 10'h000);
    step(100);
    chk(fault_log, 10'h009);
    chk({7'h00, gate_disable, f1, f2}, 10'h005);
    fet_on_cmd = 6'h00;
    ds_cmp_excess = 6'h00;
    u_flag_ctrl_model.read_log(rd);
    chk(rd, 10'h009);
    step(10);
    chk({fault_log[7:0], gate_disable, f1 | f2}, 10'h000);
  endtask
  task automatic t_esf_low();
    stop_on_fault_select = 1'b0;
    fet_on_cmd = 6'h10;
    ds_cmp_excess = 6'h10;
    step(300);
    chk({7'h00, gate_disable, f1, f2}, 10'h001);
    ds_cmp_excess = 6'h00;
    step(10);
    chk({fault_log[7:0], f1, f2}, 10'h040);
    fet_on_cmd = 6'h00;
    reg_uv = 1'b1;
    boot_uv = 3'h4;
    step(10);
    chk({8'h00, f1, f2}, 10'h003);
    reg_uv = 1'b0;
    boot_uv = 3'h0;
    step(10);
    chk({fault_log[9:8], fault_log[6:0], f2}, 10'h2a1);
    u_flag_ctrl_model.read_log(rd);
    chk(rd, 10'h250);
    step(10);
    chk({fault_log[7:0], f1, f2}, 10'h000);
  endtask
  task automatic t_uv_ot();
    reg_uv = 1'b1;
    step(10);
    reg_uv = 1'b0;
    logic_uv = 1'b1;
    step(10);
    chk({fault_log[7:0], f1, f2}, 10'h003);
    logic_uv = 1'b0;
    over_temp = 1'b1;
    step(10);
    chk({fault_log[7:0], f1, f2}, 10'h002);
    u_flag_ctrl_model.read_log(rd);
    chk({fault_log[7:0], f1, f2}, 10'h002);
    over_temp = 1'b0;
    step(10);
    chk({8'h00, f1, f2}, 10'h000);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {rst_n, stop_on_fault_select, reg_uv, logic_uv, over_temp, boot_uv} = 8'h00;
    fet_on_cmd = 6'h00;
    ds_cmp_excess = 6'h00;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    step(5);
    t_short();
    t_esf_low();
    t_uv_ot();
    complete_run();
  end
  initial begin
    #100000;
    mismatches++;
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
